// [radc_cfg.svh]
/*
 Register indices, field positions, reset values and response codes of the
 retry and line diagnosis control block.
 Assumes it is included by its bare name after the package is compiled.
*/
`ifndef RADC_CFG_SVH
`define RADC_CFG_SVH
`define RADC_IDX_TX_CTRL   4'h1
`define RADC_IDX_DIAG_CTRL 4'h2
`define RADC_IDX_OWN_CTRL  4'h8
`define RADC_IDX_OWN_STAT  4'h9
`define RADC_LIMIT_LSB     4
`define RADC_REV_LSB       1
`define RADC_KIND_BIT      0
`define RADC_DIV_LSB       4
`define RADC_MSEL_LSB      2
`define RADC_TXDIAG_BIT    1
`define RADC_DCLK_EN_BIT   0
`define RADC_PULSE_BIT     0
`define RADC_REARB_BIT     1
`define RADC_ST_RETRY_LSB  0
`define RADC_ST_REARB_BIT  4
`define RADC_ST_PROG_BIT   5
`define RADC_ST_LINE_LSB   6
`define RADC_ST_REVERR_BIT 8
`define RADC_LIMIT_RESET   4'h0
`define RADC_KIND_RESET    1'h0
`define RADC_DGC_RESET     8'h00
`define RADC_RESP_OKAY     2'h0
`define RADC_RESP_SLVERR   2'h2
`endif

// [radc_pkg.sv]
/*
 Types shared by the retry and line diagnosis control block.
 Assumes nothing of its surroundings.
*/
package radc_pkg;
	// Receive line choice, coded as the two line select bits
	typedef enum logic [1:0] {
		RADC_SEL_DIFF = 2'b00,
		RADC_SEL_TWO  = 2'b01,
		RADC_SEL_ONE  = 2'b10,
		RADC_SEL_AUTO = 2'b11
	} radc_line_sel_e;
endpackage

// [radc_diag_div.sv]
/*
 Diagnosis clock divider, stepped by timeslot ticks.
 Assumes timeslot_tick is a one-cycle pulse on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module radc_diag_div #(
	parameter int W = 4
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         timeslot_tick,
	input  wire logic         enable,
	input  wire logic [W-1:0] divide_sel,
	output logic              diag_tick,
	output logic              diag_clk
);
	logic [W-1:0] cnt_q;

	// Count timeslots, wrap after divide_sel plus one of them
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !enable)
		begin
			cnt_q     <= '0;
			diag_tick <= 1'b0;
			diag_clk  <= 1'b0;
		end
		else
		begin
			diag_tick <= 1'b0;
			if (timeslot_tick)
			begin
				if (cnt_q >= divide_sel)
				begin
					cnt_q     <= '0;
					diag_tick <= 1'b1;
					diag_clk  <= ~diag_clk;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [radc_retry.sv]
/*
 Retry counter for frame transmission attempts.
 Assumes the frame engine pulses one attempt event per attempt end.
*/
`timescale 1ns/1ps
`default_nettype none
module radc_retry (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] retry_limit,
	input  wire logic       attempt_start,
	input  wire logic       attempt_error,
	input  wire logic       attempt_lost,
	input  wire logic       attempt_ok,
	input  wire logic       rearb_req,
	output logic [3:0]      retry_count,
	output logic [4:0]      attempt_total,
	output logic            retransmit,
	output logic            give_up,
	output logic            reselect,
	output logic            rearb_pending
);
	logic active_q;
	logic end_evt;
	logic limit_hit;
	logic resel_now;

	assign end_evt   = attempt_error | attempt_lost | attempt_ok;
	assign limit_hit = attempt_error && (retry_count >= retry_limit);
	assign resel_now = rearb_pending && (end_evt || !active_q);

	// Attempt in flight
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			active_q <= 1'b0;
		else if (attempt_start)
			active_q <= 1'b1;
		else if (end_evt)
			active_q <= 1'b0;
	end

	// Retry counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			retry_count <= 4'h0;
		else if (resel_now)
			retry_count <= 4'h0;
		else if (attempt_ok || limit_hit)
			retry_count <= 4'h0;
		else if (attempt_error)
			retry_count <= retry_count + 4'h1;
	end

	// Pulses to the frame engine; lost contention retries freely
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			retransmit <= 1'b0;
			give_up    <= 1'b0;
			reselect   <= 1'b0;
		end
		else
		begin
			retransmit <= !rearb_pending && (attempt_lost || (attempt_error && !limit_hit));
			give_up    <= !rearb_pending && limit_hit;
			reselect   <= resel_now;
		end
	end

	// Pending re-arbitration, request wins over completion
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rearb_pending <= 1'b0;
		else if (rearb_req)
			rearb_pending <= 1'b1;
		else if (resel_now)
			rearb_pending <= 1'b0;
	end

	// Transmissions made so far, 16 meaning 16 or more
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			attempt_total <= 5'h01;
		else
			attempt_total <= {1'b0, retry_count} + 5'h01;
	end
endmodule
`default_nettype wire

// [radc_top.sv]
/*
 Retry and line diagnosis control: AXI4-Lite register bank, retry counter,
 receive line selection, transmission-in-progress and diagnosis clock.
 Assumes the frame engine, timeslot tick and automatic line choice come
 from logic on aclk; the three line inputs are asynchronous pins.
*/
// Decided for this implementation: register access over AXI4-Lite.
// What this block does
// - Retry limit field bounds retransmissions after transmission errors.
// - Codes 0 to 14 give that many retries; code 15 gives 15, shown 16+.
// - Lost contention is no error; retry forever without using the limit.
// - Revision field holds a fixed code; software writes that code back.
// - Module kind one allows rank 0, rank 1 or rank 16 operation.
// - Module kind zero allows only rank 1 or rank 16, never rank 0.
// - Transmit control is read and write and loads its default on reset.
// - Diagnosis control is read and write and resets to zero.
// - Upper four diagnosis control bits set the diagnosis clock divider.
// - Diagnosis clock divider steps on timeslot ticks, not the raw clock.
// - Middle bits pick differential, second, first input or automatic.
// - Transmission diag enable one generates the in-progress signal.
// - In-progress signal tells diagnosis to check transmission while sending.
// - Lowest bit enables the diagnosis clock divider; zero disables it.
// - Re-arbitrate finishes the attempt, clears retries, reselects a message.
// - Pulsed coding uses only the differential input; diagnosis is off.
`include "radc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module radc_top #(
	parameter int         ADDR_W   = 8,
	parameter logic [2:0] REVISION = 3'h6 // Arbitrary value
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              line_in_diff,
	input  wire logic              line_in_one,
	input  wire logic              line_in_two,
	input  wire logic [1:0]        auto_line_choice,
	input  wire logic              timeslot_tick,
	input  wire logic              tx_busy,
	input  wire logic              attempt_start,
	input  wire logic              attempt_error,
	input  wire logic              attempt_lost,
	input  wire logic              attempt_ok,
	output logic                   rx_data,
	output logic [1:0]             rx_line_used,
	output logic                   tx_in_progress,
	output logic                   diag_tick,
	output logic                   diag_clk,
	output logic                   diag_system_enable,
	output logic                   pulse_coding_sel,
	output logic                   rank0_allowed,
	output logic [3:0]             retry_limit,
	output logic [3:0]             retry_count,
	output logic [4:0]             attempt_total,
	output logic                   retransmit,
	output logic                   give_up,
	output logic                   reselect
);
	// Register state
	logic              module_kind_q;
	logic [3:0]        diag_clock_divider_q;
	logic              line_select_hi_q;
	logic              line_select_lo_q;
	logic              tx_diag_enable_q;
	logic              diag_clock_enable_q;
	logic              rev_err_q;
	logic              rearb_req_q;
	logic              rearb_pending;
	// Write channel holding
	logic              aw_held_q;
	logic              w_held_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              do_write;
	logic              wr_hit_txc;
	logic              wr_hit_dgc;
	logic              wr_hit_ctl;
	logic              wr_hit_sta;
	logic              wr_mapped;
	// Read path
	logic [31:0]       rd_word;
	logic              rd_mapped;
	// Line inputs
	logic [2:0]        line_raw;
	logic [2:0]        sync1_q;
	logic [2:0]        sync2_q;
	radc_pkg::radc_line_sel_e sel_eff;
	logic [1:0]        line_pick;

	// Address decode of a held write or a read address; words above the map are unmapped
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
		hit = (a[ADDR_W-1:2] == {{(ADDR_W-6){1'b0}}, idx}) && (a[1:0] == 2'h0);
	endfunction

	assign wr_hit_txc = hit(waddr_q, `RADC_IDX_TX_CTRL);
	assign wr_hit_dgc = hit(waddr_q, `RADC_IDX_DIAG_CTRL);
	assign wr_hit_ctl = hit(waddr_q, `RADC_IDX_OWN_CTRL);
	assign wr_hit_sta = hit(waddr_q, `RADC_IDX_OWN_STAT);
	assign wr_mapped  = wr_hit_txc | wr_hit_dgc | wr_hit_ctl | wr_hit_sta;

	// Channel readies: one write and one read in flight
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_held_q && w_held_q;

	// Hold the write address until the data has come too
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			waddr_q   <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_q <= 1'b1;
			waddr_q   <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held_q <= 1'b0;
	end

	// Hold the write data until the address has come too
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end
		else if (do_write)
			w_held_q <= 1'b0;
	end

	// Write response, one cycle after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RADC_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? `RADC_RESP_OKAY : `RADC_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Transmit control: retry limit and module kind, revision is fixed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			retry_limit   <= `RADC_LIMIT_RESET;
			module_kind_q <= `RADC_KIND_RESET;
		end
		else if (do_write && wr_hit_txc && wstrb_q[0])
		begin
			retry_limit   <= wdata_q[`RADC_LIMIT_LSB +: 4];
			module_kind_q <= wdata_q[`RADC_KIND_BIT];
		end
	end

	// Sticky flag for a revision write other than the fixed code
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rev_err_q <= 1'b0;
		else if (do_write && wr_hit_txc && wstrb_q[0]
			&& (wdata_q[`RADC_REV_LSB +: 3] != REVISION))
			rev_err_q <= 1'b1;
		else if (do_write && wr_hit_sta && wstrb_q[1] && wdata_q[`RADC_ST_REVERR_BIT])
			rev_err_q <= 1'b0;
	end

	// Diagnosis control fields
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			diag_clock_divider_q <= 4'(`RADC_DGC_RESET >> `RADC_DIV_LSB);
			line_select_hi_q     <= 1'b0;
			line_select_lo_q     <= 1'b0;
			tx_diag_enable_q     <= 1'b0;
			diag_clock_enable_q  <= 1'b0;
		end
		else if (do_write && wr_hit_dgc && wstrb_q[0])
		begin
			diag_clock_divider_q <= wdata_q[`RADC_DIV_LSB +: 4];
			line_select_hi_q     <= wdata_q[`RADC_MSEL_LSB + 1];
			line_select_lo_q     <= wdata_q[`RADC_MSEL_LSB];
			tx_diag_enable_q     <= wdata_q[`RADC_TXDIAG_BIT];
			diag_clock_enable_q  <= wdata_q[`RADC_DCLK_EN_BIT];
		end
	end

	// Own control: coding choice and the re-arbitrate strobe
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pulse_coding_sel <= 1'b0;
			rearb_req_q      <= 1'b0;
		end
		else
		begin
			rearb_req_q <= do_write && wr_hit_ctl && wstrb_q[0] && wdata_q[`RADC_REARB_BIT];
			if (do_write && wr_hit_ctl && wstrb_q[0])
				pulse_coding_sel <= wdata_q[`RADC_PULSE_BIT];
		end
	end

	// Read word of the addressed register
	always_comb
	begin
		rd_word   = 32'h0000_0000;
		rd_mapped = 1'b1;
		if (hit(s_axi_araddr, `RADC_IDX_TX_CTRL))
		begin
			rd_word[`RADC_LIMIT_LSB +: 4] = retry_limit;
			rd_word[`RADC_REV_LSB +: 3]   = REVISION;
			rd_word[`RADC_KIND_BIT]       = module_kind_q;
		end
		else if (hit(s_axi_araddr, `RADC_IDX_DIAG_CTRL))
		begin
			rd_word[`RADC_DIV_LSB +: 4]   = diag_clock_divider_q;
			rd_word[`RADC_MSEL_LSB + 1]   = line_select_hi_q;
			rd_word[`RADC_MSEL_LSB]       = line_select_lo_q;
			rd_word[`RADC_TXDIAG_BIT]     = tx_diag_enable_q;
			rd_word[`RADC_DCLK_EN_BIT]    = diag_clock_enable_q;
		end
		else if (hit(s_axi_araddr, `RADC_IDX_OWN_CTRL))
			rd_word[`RADC_PULSE_BIT] = pulse_coding_sel;
		else if (hit(s_axi_araddr, `RADC_IDX_OWN_STAT))
		begin
			rd_word[`RADC_ST_RETRY_LSB +: 4] = retry_count;
			rd_word[`RADC_ST_REARB_BIT]      = rearb_pending;
			rd_word[`RADC_ST_PROG_BIT]       = tx_in_progress;
			rd_word[`RADC_ST_LINE_LSB +: 2]  = rx_line_used;
			rd_word[`RADC_ST_REVERR_BIT]     = rev_err_q;
		end
		else
			rd_mapped = 1'b0;
	end

	// Read data channel, answer one cycle after the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `RADC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_mapped ? `RADC_RESP_OKAY : `RADC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Two-flop synchronisers for the three line inputs
	assign line_raw = {line_in_two, line_in_one, line_in_diff};
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					sync1_q[i] <= 1'b1; // Recessive idle level
					sync2_q[i] <= 1'b1;
				end
				else
				begin
					sync1_q[i] <= line_raw[i];
					sync2_q[i] <= sync1_q[i];
				end
			end
		end
	endgenerate

	// Effective line choice; pulsed coding forces the differential input
	always_comb
	begin
		if (pulse_coding_sel)
			sel_eff = radc_pkg::RADC_SEL_DIFF;
		else
			sel_eff = radc_pkg::radc_line_sel_e'({line_select_hi_q, line_select_lo_q});
		unique case (sel_eff)
			radc_pkg::RADC_SEL_DIFF: line_pick = 2'h0;
			radc_pkg::RADC_SEL_TWO:  line_pick = 2'h2;
			radc_pkg::RADC_SEL_ONE:  line_pick = 2'h1;
			radc_pkg::RADC_SEL_AUTO: line_pick = (auto_line_choice == 2'h3) ? 2'h0
				: auto_line_choice;
		endcase
	end

	// Registered receive data and the index of the line in use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_data      <= 1'b1;
			rx_line_used <= 2'h0;
		end
		else
		begin
			rx_data      <= sync2_q[line_pick];
			rx_line_used <= line_pick;
		end
	end

	// Transmission in progress for the diagnosis system
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tx_in_progress <= 1'b0;
		else
			tx_in_progress <= tx_diag_enable_q && tx_busy && !pulse_coding_sel;
	end

	// Diagnosis runs only under normal coding; rank 0 only with module kind one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			diag_system_enable <= 1'b0;
			rank0_allowed      <= 1'b0;
		end
		else
		begin
			diag_system_enable <= !pulse_coding_sel;
			rank0_allowed      <= module_kind_q;
		end
	end

	// Diagnosis clock divider on timeslot ticks
	radc_diag_div #(
		.W(4)
	) u_div (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.timeslot_tick (timeslot_tick),
		.enable        (diag_clock_enable_q && !pulse_coding_sel),
		.divide_sel    (diag_clock_divider_q),
		.diag_tick     (diag_tick),
		.diag_clk      (diag_clk)
	);

	// Retry counter and re-arbitration
	radc_retry u_retry (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.retry_limit   (retry_limit),
		.attempt_start (attempt_start),
		.attempt_error (attempt_error),
		.attempt_lost  (attempt_lost),
		.attempt_ok    (attempt_ok),
		.rearb_req     (rearb_req_q),
		.retry_count   (retry_count),
		.attempt_total (attempt_total),
		.retransmit    (retransmit),
		.give_up       (give_up),
		.reselect      (reselect),
		.rearb_pending (rearb_pending)
	);
endmodule
`default_nettype wire

// [radc_chk_sva.sv]
/*
 Port checks for the retry and line diagnosis control top.
 Assumes it is bound to radc_top from the testbench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module radc_chk (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       timeslot_tick,
	input wire logic       tx_busy,
	input wire logic       attempt_error,
	input wire logic       attempt_lost,
	input wire logic       attempt_ok,
	input wire logic       tx_in_progress,
	input wire logic       diag_tick,
	input wire logic       pulse_coding_sel,
	input wire logic [1:0] rx_line_used,
	input wire logic [3:0] retry_limit,
	input wire logic [3:0] retry_count,
	input wire logic [4:0] attempt_total,
	input wire logic       retransmit,
	input wire logic       give_up,
	input wire logic       reselect
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write halves taken at one edge; a read request taken
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Bus answers and holds
	AST_WR_RESP: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_RD_RESP: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid)
		else $error("read response missing");
	// Retry counting
	AST_RETRY_UP: assert property (attempt_error && retry_count < retry_limit
		|-> ##[1:2] (retransmit || reselect)) else $error("no retransmit below limit");
	AST_GIVE_UP: assert property (attempt_error && retry_count >= retry_limit
		|-> ##[1:2] (give_up || reselect)) else $error("no give up at limit");
	AST_LOST: assert property (attempt_lost |=> !give_up [*2])
		else $error("lost contention counted as error");
	AST_OK_CLEAR: assert property (attempt_ok |-> ##2 retry_count == 4'h0)
		else $error("retry count not cleared on success");
	AST_TOTAL: assert property (retry_count == $past(retry_count)
		&& retry_count == $past(retry_count, 2)
		|-> attempt_total == {1'b0, retry_count} + 5'h01) else $error("attempt total wrong");
	// Diagnosis side
	AST_TX_PROG: assert property (!$past(tx_busy) |-> !tx_in_progress)
		else $error("in-progress without sending");
	AST_PULSE: assert property (pulse_coding_sel [*3]
		|-> rx_line_used == 2'h0 && !tx_in_progress) else $error("pulse coding not on diff");
	AST_DIAG_STEP: assert property (diag_tick
		|-> $past(timeslot_tick) || $past(timeslot_tick, 2)) else $error("tick off timeslot");
endmodule
`default_nettype wire

// [radc_line_model.sv]
/*
 Line receivers and timeslot source facing the block.
 Assumes the bench sets the level seen on each line.
*/
`timescale 1ns/1ps
`default_nettype none
module radc_line_model #(
	parameter int SLOT = 4
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [2:0] level,
	output logic            line_in_diff,
	output logic            line_in_one,
	output logic            line_in_two,
	output logic            timeslot_tick
);
	logic [7:0] slot_q;
	// Each receiver shows its bus level
	assign line_in_diff = level[0];
	assign line_in_one  = level[1];
	assign line_in_two  = level[2];
	// Timeslot pulse every SLOT cycles
	always_ff @(posedge aclk)
	begin
		if (!aresetn || slot_q == 8'(SLOT - 1))
			slot_q <= 8'h00;
		else
			slot_q <= slot_q + 8'h01;
	end
	assign timeslot_tick = aresetn && slot_q == 8'(SLOT - 1);
endmodule
`default_nettype wire

// [retry_and_line_diag_control_tb_top.sv]
/*
 Self-checking bench for the retry and line diagnosis control block.
 Assumes the design, checker and line model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module retry_and_line_diag_control_tb_top;
	localparam logic [2:0] REV = 3'h5; // Arbitrary value
	localparam int SLOT = 4;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, busy = 0;
	logic st = 0, er = 0, lo = 0, ok = 0, ta, tw, tr, rt, gu, rs, diag_on;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, d, rdat;
	logic [1:0] bresp, rresp, used, alc = 2'h1;
	logic [2:0] lvl = 3'b010;
	logic awr, wr_r, bv, arr, rv, ld, l1, l2, tick, rxd, prog, dtk, pcs, dclk;
	logic [3:0] lim, cnt;
	logic [4:0] tot;
	int errors = 0, comparisons = 0, n;
	logic [1:0] used_tab [4] = '{2'h0, 2'h2, 2'h1, 2'h1};
	radc_top #(.REVISION(REV)) uut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .line_in_diff(ld),
		.line_in_one(l1), .line_in_two(l2), .auto_line_choice(alc), .timeslot_tick(tick),
		.tx_busy(busy), .attempt_start(st), .attempt_error(er), .attempt_lost(lo),
		.attempt_ok(ok), .rx_data(rxd), .rx_line_used(used), .tx_in_progress(prog),
		.diag_tick(dtk), .diag_clk(dclk), .diag_system_enable(diag_on), .pulse_coding_sel(pcs),
		.rank0_allowed(), .retry_limit(lim), .retry_count(cnt), .attempt_total(tot),
		.retransmit(), .give_up(), .reselect());
	radc_line_model #(.SLOT(SLOT)) far (.aclk, .aresetn, .level(lvl), .line_in_diff(ld),
		.line_in_one(l1), .line_in_two(l2), .timeslot_tick(tick));
	// Clock
	always #2 aclk = ~aclk;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er_exp);
		logic pa, pw, dn;
		pa = 1;
		pw = 1;
		dn = 0;
		n = 0;
		@(posedge aclk);
		{awa, wd, awv, wv, bry} <= {a, v, 3'b111};
		while (!dn && n < 100)
		begin
			@(negedge aclk);
			ta = pa && awr;
			tw = pw && wr_r;
			tr = bv;
			if (tr) chk("bresp", 32'(bresp), 32'(er_exp));
			@(posedge aclk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tr) bry <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
			dn = tr;
			n++;
		end
		if (!dn) chk("write done", 0, 1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er_exp);
		n = 0;
		tr = 0;
		@(posedge aclk);
		{ara, arv, rry} <= {a, 2'b11};
		while (!tr && n < 100)
		begin
			@(negedge aclk);
			ta = arv && arr;
			tr = rv;
			d = rdat;
			if (tr) chk("rresp", 32'(rresp), 32'(er_exp));
			@(posedge aclk);
			if (ta) arv <= 1'b0;
			if (tr) rry <= 1'b0;
			n++;
		end
		if (!tr) chk("read done", 0, 1);
	endtask
	// One attempt: start, then error, lost or ok; pulses gathered after it
	task automatic ev(input int k, input logic s);
		@(posedge aclk);
		st <= s;
		@(posedge aclk);
		{st, er, lo, ok} <= {1'b0, k == 0, k == 1, k == 2};
		{rt, gu, rs} = 3'b000;
		@(posedge aclk);
		{er, lo, ok} <= 3'b000;
		repeat (4)
		begin
			@(negedge aclk);
			{rt, gu, rs} = {rt | uut.retransmit, gu | uut.give_up, rs | uut.reselect};
		end
	endtask
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge aclk);
		errors++;
		print_verdict();
	end
	// Test sequence
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h04, 2'h0);
		chk("tx ctrl reset", d, {24'h0000_00, 4'h0, REV, 1'b0});
		rd(8'h08, 2'h0);
		chk("diag ctrl reset", d, 32'h0000_0000);
		rd(8'h0C, 2'h2);
		wr(8'h0C, 32'h0000_00FF, 2'h2);
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h04, {24'h0000_00, 4'hF, REV, k[0]}, 2'h0);
			rd(8'h04, 2'h0);
			chk("tx ctrl", d, {24'h0000_00, 4'hF, REV, k[0]});
			chk("rank0", 32'(uut.rank0_allowed), 32'(k));
			chk("limit out", 32'(lim), 32'h0000_000F);
		end
		wr(8'h04, {24'h0000_00, 4'h2, ~REV, 1'b0}, 2'h0);
		rd(8'h04, 2'h0);
		chk("revision", d, {24'h0000_00, 4'h2, REV, 1'b0});
		rd(8'h24, 2'h0);
		chk("revision flag", 32'(d[8]), 1);
		wr(8'h24, 32'h0000_0100, 2'h0);
		rd(8'h24, 2'h0);
		chk("revision flag clear", 32'(d[8]), 0);
		$display("test registers done");
		ev(0, 1);
		chk("retry one", {rt, gu, 24'h0, cnt}, {2'b10, 24'h0, 4'h1});
		ev(1, 1);
		chk("lost", {rt, gu, 24'h0, cnt}, {2'b10, 24'h0, 4'h1});
		ev(0, 1);
		ev(0, 1);
		chk("limit two", {rt, gu, 24'h0, cnt}, {2'b01, 24'h0, 4'h0});
		ev(0, 1);
		ev(2, 1);
		chk("ok clear", {rt, gu, 24'h0, cnt}, {2'b00, 24'h0, 4'h0});
		wr(8'h04, {24'h0000_00, 4'hF, REV, 1'b0}, 2'h0);
		repeat (15) ev(0, 1);
		chk("fifteen", {23'h0, tot, cnt}, {23'h0, 5'h10, 4'hF});
		ev(0, 1);
		chk("give up", {gu, 27'h0, cnt}, {1'b1, 27'h0, 4'h0});
		ev(0, 1);
		@(posedge aclk);
		st <= 1'b1;
		@(posedge aclk);
		st <= 1'b0;
		wr(8'h20, 32'h0000_0002, 2'h0);
		ev(0, 0);
		chk("rearb", {rt, gu, rs, 25'h0, cnt}, {3'b001, 25'h0, 4'h0});
		$display("test retry done");
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h08, {24'h0000_00, 4'h0, 2'(s), 2'b00}, 2'h0);
			repeat (5) @(negedge aclk);
			chk("line", {used, 29'h0, rxd}, {used_tab[s], 29'h0, lvl[used_tab[s]]});
		end
		@(posedge aclk);
		alc <= 2'h2;
		repeat (5) @(negedge aclk);
		chk("auto", {used, 29'h0, rxd}, {2'h2, 29'h0, lvl[2]});
		wr(8'h20, 32'h0000_0001, 2'h0);
		repeat (5) @(negedge aclk);
		chk("pulse coding", {used, diag_on, pcs}, {2'h0, 2'b01});
		wr(8'h20, 32'h0000_0000, 2'h0);
		wr(8'h08, 32'h0000_0002, 2'h0);
		busy <= 1'b1;
		repeat (3) @(negedge aclk);
		chk("prog on", 32'(prog), 1);
		wr(8'h08, 32'h0000_0000, 2'h0);
		repeat (3) @(negedge aclk);
		chk("prog off", 32'(prog), 0);
		busy <= 1'b0;
		wr(8'h08, 32'h0000_0021, 2'h0);
		n = 0;
		while (!dtk && n < 200)
		begin
			@(negedge aclk);
			n++;
		end
		d[0] = dclk;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (!dtk && n < 200);
		chk("diag gap", n, 3 * SLOT);
		chk("diag clk", 32'(dclk), 32'(!d[0]));
		wr(8'h08, 32'h0000_0020, 2'h0);
		n = 0;
		repeat (40)
		begin
			@(negedge aclk);
			n += dtk;
		end
		chk("diag off", n, 0);
		$display("test diagnosis done");
		print_verdict();
	end
endmodule
bind radc_top radc_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.timeslot_tick, .tx_busy, .attempt_error, .attempt_lost, .attempt_ok, .tx_in_progress,
	.diag_tick, .pulse_coding_sel, .rx_line_used, .retry_limit, .retry_count, .attempt_total,
	.retransmit, .give_up, .reselect);
`default_nettype wire
